// ===== rtl/lbec_top.sv
/*
  link bridge error command and link control registers with axi4-lite
  slave, target-abort to system-error message decision and interrupt.
  assumes target_abort_i is a one-cycle pulse from link logic on aclk,
  and that the link logic accepts err_msg_q as a one-cycle request.
*/
// Summary of operation
// R1 - error command is 8 bits at 0x40, reset zero, only bit 0 writable
// R2 - abort enable clear: no system-error message on received target abort
// R3 - abort enable set: send system-error message on each target abort
// R4 - no message at all unless the global error-message enable is set
// R5 - link control bits 31:29 hold the lowest downstream hub number
// R6 - link control bits 27:25 hold the highest downstream hub number
// R7 - link control bits 15:14 give bus width; only 00 (8 bit) legal
// R8 - reserved link control bits keep reset values, ignore writes
`default_nettype none
module lbec_top
  import lbec_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // streaming link side
  input wire logic target_abort_i,
  output logic err_msg_q,
  output logic [2:0] first_downstream_hub_number_q,
  output logic [2:0] last_downstream_hub_number_q,
  output logic [1:0] link_bus_width_q,
  // interrupt
  output logic irq_q
);

  // register state
  logic [7:0] link_error_command_q, link_error_command_d;
  logic [31:0] link_control_q, link_control_d;
  logic global_err_en_q, global_err_en_d;
  logic [LBEC_IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [15:0] msg_cnt_q, msg_cnt_d;
  logic [LBEC_IRQ_W-1:0] irq_stat;
  logic [LBEC_IRQ_W-1:0] irq_set;
  logic [LBEC_IRQ_W-1:0] irq_clr;

  // write channel state
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;

  // read channel state
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // link side state
  logic err_msg_d;
  logic irq_d;

  logic wr_fire;
  logic wr_hit;
  logic [31:0] wr_mask;
  logic bad_width;

  // expand byte strobes to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_mask[i*8 +: 8] = {8{w_strb_q[i]}};
    end
  end

  // a write commits once both address and data are held and b is free
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

  // write address and data channels, taken in either order
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? LBEC_RESP_OKAY : LBEC_RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // ready is withheld while a channel item waits for its partner
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= LBEC_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // address decode for writes; unmapped offsets answer slverr
  always_comb begin
    case (aw_addr_q)
      LBEC_OFF_ERRCMD, LBEC_OFF_LINKCTL, LBEC_OFF_GLOBAL,
      LBEC_OFF_IRQ_STAT, LBEC_OFF_IRQ_MASK, LBEC_OFF_MSG_CNT: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  // register writes and message counter
  always_comb begin
    link_error_command_d = link_error_command_q;
    link_control_d = link_control_q;
    global_err_en_d = global_err_en_q;
    irq_mask_d = irq_mask_q;
    msg_cnt_d = msg_cnt_q;
    irq_clr = '0;
    if (wr_fire) begin
      case (aw_addr_q)
        LBEC_OFF_ERRCMD: begin
          // R1 only bit 0 writable
          if (w_strb_q[0]) begin
            link_error_command_d[LBEC_ABORT_EN_BIT] =
              w_data_q[LBEC_ABORT_EN_BIT];
          end
        end
        LBEC_OFF_LINKCTL: begin
          // R5 R6 R7 R8 masked field write
          link_control_d = (link_control_q &
            ~(LBEC_LINKCTL_WMASK & wr_mask)) |
            (w_data_q & LBEC_LINKCTL_WMASK & wr_mask);
        end
        LBEC_OFF_GLOBAL: begin
          if (w_strb_q[0]) begin
            global_err_en_d = w_data_q[0];
          end
        end
        LBEC_OFF_IRQ_STAT: begin
          if (w_strb_q[0]) begin
            irq_clr = w_data_q[LBEC_IRQ_W-1:0];
          end
        end
        LBEC_OFF_IRQ_MASK: begin
          if (w_strb_q[0]) begin
            irq_mask_d = w_data_q[LBEC_IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    // counter saturates rather than wrapping back to a small value
    if (err_msg_d && msg_cnt_q != 16'hffff) begin
      msg_cnt_d = msg_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_error_command_q <= LBEC_ERRCMD_RST;
      link_control_q <= LBEC_LINKCTL_RST;
      global_err_en_q <= 1'b0;
      irq_mask_q <= '0;
      msg_cnt_q <= 16'h0000;
    end else begin
      link_error_command_q <= link_error_command_d;
      link_control_q <= link_control_d;
      global_err_en_q <= global_err_en_d;
      irq_mask_q <= irq_mask_d;
      msg_cnt_q <= msg_cnt_d;
    end
  end

  // R7 flag a reserved width code written by software
  assign bad_width =
    link_control_q[LBEC_WIDTH_HI:LBEC_WIDTH_LO] != LBEC_WIDTH_8BIT;

  // R2 R3 R4 message request from abort and both enables
  always_comb begin
    err_msg_d = target_abort_i && global_err_en_q &&
      link_error_command_q[LBEC_ABORT_EN_BIT];
  end

  // interrupt events
  assign irq_set[LBEC_IRQ_ABORT] = target_abort_i;
  assign irq_set[LBEC_IRQ_MSG] = err_msg_d;
  assign irq_set[LBEC_IRQ_BADW] = bad_width;

  // the width flag re-sets every cycle while the code is bad, so a
  // clear only sticks once software restores the 8 bit code
  // one sticky bit per event
  for (genvar g = 0; g < LBEC_IRQ_W; g++) begin : g_stat
    lbec_sticky u_sticky (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_i(irq_set[g]),
      .clr_i(irq_clr[g]),
      .flag_q(irq_stat[g])
    );
  end

  // mask only gates the output; status bits keep recording events
  // so software can poll with the interrupt disabled
  assign irq_d = |(irq_stat & irq_mask_q);

  // read channel: one read at a time, answered a cycle after arvalid
  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = LBEC_RESP_OKAY;
      case (s_axi_araddr)
        LBEC_OFF_ERRCMD: rdata_d = {24'h00_0000, link_error_command_q};
        LBEC_OFF_LINKCTL: rdata_d = link_control_q;
        LBEC_OFF_GLOBAL: rdata_d = {31'h0000_0000, global_err_en_q};
        LBEC_OFF_IRQ_STAT: rdata_d = {29'h0000_0000, irq_stat};
        LBEC_OFF_IRQ_MASK: rdata_d = {29'h0000_0000, irq_mask_q};
        LBEC_OFF_MSG_CNT: rdata_d = {16'h0000, msg_cnt_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = LBEC_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= LBEC_RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // link-facing outputs, registered; hub and width copies lag
  // link_control by one cycle, which the link logic must allow for
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_msg_q <= 1'b0;
      irq_q <= 1'b0;
      first_downstream_hub_number_q <=
        LBEC_LINKCTL_RST[LBEC_FIRST_HI:LBEC_FIRST_LO];
      last_downstream_hub_number_q <=
        LBEC_LINKCTL_RST[LBEC_LAST_HI:LBEC_LAST_LO];
      link_bus_width_q <= LBEC_LINKCTL_RST[LBEC_WIDTH_HI:LBEC_WIDTH_LO];
    end else begin
      err_msg_q <= err_msg_d;
      irq_q <= irq_d;
      first_downstream_hub_number_q <=
        link_control_q[LBEC_FIRST_HI:LBEC_FIRST_LO];
      last_downstream_hub_number_q <=
        link_control_q[LBEC_LAST_HI:LBEC_LAST_LO];
      link_bus_width_q <= link_control_q[LBEC_WIDTH_HI:LBEC_WIDTH_LO];
    end
  end

  // bus outputs are the channel flip-flops themselves
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : lbec_top
`default_nettype wire

// ===== rtl/lbec_pkg.sv
/*
  package for the link bridge error and link control register bank:
  register offsets, field positions, reset values, interrupt layout.
  assumes nothing beyond a plain systemverilog compile.
*/
`default_nettype none
package lbec_pkg;
  // byte addresses on the register bus
  localparam logic [7:0] LBEC_OFF_ERRCMD = 8'h40;
  localparam logic [7:0] LBEC_OFF_LINKCTL = 8'h50;
  localparam logic [7:0] LBEC_OFF_GLOBAL = 8'h60;
  localparam logic [7:0] LBEC_OFF_IRQ_STAT = 8'h64;
  localparam logic [7:0] LBEC_OFF_IRQ_MASK = 8'h68;
  localparam logic [7:0] LBEC_OFF_MSG_CNT = 8'h6c;
  // reset values
  localparam logic [7:0] LBEC_ERRCMD_RST = 8'h00;
  localparam logic [31:0] LBEC_LINKCTL_RST = 32'h0e04_2802;
  // field positions
  localparam int LBEC_ABORT_EN_BIT = 0;
  localparam int LBEC_FIRST_HI = 31;
  localparam int LBEC_FIRST_LO = 29;
  localparam int LBEC_LAST_HI = 27;
  localparam int LBEC_LAST_LO = 25;
  localparam int LBEC_WIDTH_HI = 15;
  localparam int LBEC_WIDTH_LO = 14;
  // writable bits of the link control word
  localparam logic [31:0] LBEC_LINKCTL_WMASK = 32'he000_0000 |
    32'h0e00_0000 | 32'h0000_c000;
  localparam logic [1:0] LBEC_WIDTH_8BIT = 2'h0;
  // interrupt status bits
  localparam int LBEC_IRQ_ABORT = 0;
  localparam int LBEC_IRQ_MSG = 1;
  localparam int LBEC_IRQ_BADW = 2;
  localparam int LBEC_IRQ_W = 3;
  // axi responses
  localparam logic [1:0] LBEC_RESP_OKAY = 2'h0;
  localparam logic [1:0] LBEC_RESP_SLVERR = 2'h2;
endpackage : lbec_pkg
`default_nettype wire

// ===== rtl/lbec_sticky.sv
/*
  one sticky event bit: set by hardware, cleared by writing a one.
  assumes set and clear arrive on the same clock.
*/
`default_nettype none
module lbec_sticky (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // event and clear
  input wire logic set_i,
  input wire logic clr_i,
  // state
  output logic flag_q
);
  logic flag_d;

  // set wins so an event in the clear cycle is kept
  always_comb begin
    flag_d = flag_q;
    if (clr_i) begin
      flag_d = 1'b0;
    end
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule : lbec_sticky
`default_nettype wire

// ===== sim/lbec_checker.sv
/* port checker for lbec_top, bound onto every instance.
   assumes one clock and a synchronous active-low reset. */
`default_nettype none
module lbec_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // link side
  input wire logic target_abort_i,
  input wire logic err_msg_q,
  input wire logic [2:0] first_downstream_hub_number_q,
  input wire logic [2:0] last_downstream_hub_number_q,
  input wire logic [1:0] link_bus_width_q,
  input wire logic irq_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a message needs an abort one cycle before
  msg_cause_a: assert property (err_msg_q |-> $past(target_abort_i))
    else $error("message without abort");
  // link fields move only after a completed write
  hub_first_a: assert property (
    !$stable(first_downstream_hub_number_q) |-> $past(s_axi_bvalid))
    else $error("first hub changed without write");
  hub_last_a: assert property (
    !$stable(last_downstream_hub_number_q) |-> $past(s_axi_bvalid))
    else $error("last hub changed without write");
  width_chg_a: assert property (
    !$stable(link_bus_width_q) |-> $past(s_axi_bvalid))
    else $error("width changed without write");
  rst_vals_a: assert property (
    $rose(aresetn) |-> first_downstream_hub_number_q == 3'h0 &&
    last_downstream_hub_number_q == 3'h7 && link_bus_width_q == 2'h0 &&
    !irq_q && !err_msg_q)
    else $error("wrong values after reset");
  // bus answers come within the promised cycles
  write_ans_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
    ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  read_ans_a: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  bhold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  msg_c: cover property (err_msg_q);
  slverr_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  irq_c: cover property (irq_q);
endmodule : lbec_checker
bind lbec_top lbec_checker chk_i (.*);
`default_nettype wire

// ===== sim/lbec_link_peer.sv
/* downstream device model on the streaming link.
   assumes err_msg_q is a one-cycle pulse on aclk. */
`default_nettype none
module lbec_link_peer (
  // clock
  input wire logic aclk,
  // link
  input wire logic err_msg_q,
  output logic target_abort_i
);
  timeunit 1ns;
  timeprecision 1ns;
  int msg_seen = 0;
  initial target_abort_i = 1'b0;
  // count received messages; negedge avoids edge race
  always @(negedge aclk) if (err_msg_q === 1'b1) msg_seen++;
  // back-to-back abort pulses, the harshest spacing
  task send_aborts(input int n);
    repeat (n) begin
      @(posedge aclk);
      target_abort_i <= 1'b1;
    end
    @(posedge aclk);
    target_abort_i <= 1'b0;
  endtask : send_aborts
endmodule : lbec_link_peer
`default_nettype wire

// ===== sim/test_link_bridge_error_and_link_ctrl.sv
/* self-checking bench for lbec_top over axi4-lite.
   assumes the link peer model and the bound checker. */
`default_nettype none
module test_link_bridge_error_and_link_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import lbec_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, target_abort_i, err_msg_q, irq_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, link_bus_width_q;
  logic [2:0] first_downstream_hub_number_q, last_downstream_hub_number_q;
  int err_count = 0, samples_checked = 0;
  lbec_top dut (.*);
  lbec_link_peer peer (.*);
  initial forever #20 aclk = ~aclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task complete_run;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // one write; handshakes seen at negedge, acted on after the next edge;
  // bready rises only after bvalid, so the response must hold a cycle
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b, bv;
    logic [1:0] rsp;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      bv = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv && !b;
    end
    if (!b) begin
      err_count++;
      complete_run();
    end
    chk({30'h0, rsp}, {30'h0, er});
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, r;
    logic [31:0] dat;
    logic [1:0] rsp;
    r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !r; n++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
    if (!r) begin
      err_count++;
      complete_run();
    end
    chk(dat, ed);
    chk({30'h0, rsp}, {30'h0, er});
  endtask : rd
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(LBEC_OFF_ERRCMD, 32'h0, LBEC_RESP_OKAY);
    rd(LBEC_OFF_LINKCTL, LBEC_LINKCTL_RST, LBEC_RESP_OKAY);
    wr(LBEC_OFF_ERRCMD, 32'hffff_ffff, LBEC_RESP_OKAY);
    rd(LBEC_OFF_ERRCMD, 32'h0000_0001, LBEC_RESP_OKAY);
    // width code kept legal; reserved bits all written as one
    wr(LBEC_OFF_LINKCTL, 32'hffff_3fff, LBEC_RESP_OKAY);
    rd(LBEC_OFF_LINKCTL, 32'hee04_2802, LBEC_RESP_OKAY);
    chk({29'h0, first_downstream_hub_number_q}, 32'h7);
    chk({29'h0, last_downstream_hub_number_q}, 32'h7);
    chk({30'h0, link_bus_width_q}, {30'h0, LBEC_WIDTH_8BIT});
    // byte 3 strobe off: hub fields must not move
    s_axi_wstrb <= 4'h7;
    wr(LBEC_OFF_LINKCTL, 32'h0000_0000, LBEC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(LBEC_OFF_LINKCTL, 32'hee04_2802, LBEC_RESP_OKAY);
    wr(LBEC_OFF_LINKCTL, 32'h4a00_0000, LBEC_RESP_OKAY);
    rd(LBEC_OFF_LINKCTL, 32'h4a04_2802, LBEC_RESP_OKAY);
    chk({29'h0, first_downstream_hub_number_q}, 32'h2);
    chk({29'h0, last_downstream_hub_number_q}, 32'h5);
    chk({30'h0, link_bus_width_q}, {30'h0, LBEC_WIDTH_8BIT});
    wr(8'h7c, 32'h1, LBEC_RESP_SLVERR);
    rd(8'h7c, 32'h0, LBEC_RESP_SLVERR);
    // every combination of abort enable and global enable
    for (int k = 0; k < 4; k++) begin
      wr(LBEC_OFF_ERRCMD, {31'h0, k[0]}, LBEC_RESP_OKAY);
      wr(LBEC_OFF_GLOBAL, {31'h0, k[1]}, LBEC_RESP_OKAY);
      peer.msg_seen = 0;
      peer.send_aborts(2);
      repeat (3) @(posedge aclk);
      chk(peer.msg_seen, (k == 3) ? 32'h2 : 32'h0);
    end
    rd(LBEC_OFF_MSG_CNT, 32'h2, LBEC_RESP_OKAY);
    @(negedge aclk);
    chk({31'h0, irq_q}, 32'h0);
    wr(LBEC_OFF_IRQ_MASK, 32'h3, LBEC_RESP_OKAY);
    @(negedge aclk);
    chk({31'h0, irq_q}, 32'h1);
    wr(LBEC_OFF_IRQ_STAT, 32'h7, LBEC_RESP_OKAY);
    @(negedge aclk);
    chk({31'h0, irq_q}, 32'h0);
    rd(LBEC_OFF_IRQ_STAT, 32'h0, LBEC_RESP_OKAY);
    // second reset in mid-run: written registers fall back
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(LBEC_OFF_ERRCMD, 32'h0, LBEC_RESP_OKAY);
    rd(LBEC_OFF_LINKCTL, LBEC_LINKCTL_RST, LBEC_RESP_OKAY);
    complete_run();
  end
endmodule : test_link_bridge_error_and_link_ctrl
`default_nettype wire
